// ---- hdl/spc_map.vh ----
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
// register byte offsets
`define SPC_OFS_CONTROL      12'h004
`define SPC_OFS_SOFT_RESET   12'h008
`define SPC_OFS_STAT_EN      12'h00c
`define SPC_OFS_PTYPE        12'h010
`define SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS  12'h028
`define SPC_OFS_P0_BLK_USE   12'h02c
`define SPC_OFS_P0_THRESH    12'h030
`define SPC_OFS_P1_THRESH    12'h050
`define SPC_OFS_P2_THRESH    12'h070
`define SPC_OFS_VLAN_ID      12'h074
// control fields
`define SPC_CTL_P2_KEEP      12
`define SPC_CTL_P1_KEEP      11
`define SPC_CTL_P0_KEEP      10
`define SPC_CTL_TAG_AWARE    9
`define SPC_CTL_ENCAP        8
`define SPC_CTL_P2_OWN_RX    7
`define SPC_CTL_P2_FROM_P1   6
`define SPC_CTL_P2_FROM_P0   5
`define SPC_CTL_P1_FROM_P2   4
`define SPC_CTL_P1_FROM_P0   3
`define SPC_CTL_P0_FROM_P2   2
`define SPC_CTL_P0_FROM_P1   1
`define SPC_CTL_LOOPBACK     0
`define SPC_CTL_RESET        13'h00e0
`define SPC_CTL_W            13
// ptype fields
`define SPC_PT_P2_ESC        10
`define SPC_PT_P1_ESC        9
`define SPC_PT_P0_ESC        8
`define SPC_PT_W             11
`define SPC_PT_RESET         11'h000
// block limits and other register reset values
`define SPC_MAX_RESET        9'h113
`define SPC_TX_MIN           5'h0e
`define SPC_RX_MIN           4'h3
`define SPC_RX_MAX           4'h6
`define SPC_STAT_RESET       3'h0
`define SPC_THR_RESET        5'h00
`define SPC_VID_RESET        12'h000
// soft reset hold in cycles
`define SPC_SRST_CYCLES      4'h4
`endif

// ---- hdl/spc_switch_port_control.v ----
// Functional notes
// R1 - per port keep bit clear: zero VLAN ID gets port default VLAN ID
// R2 - control bit 9 selects tag-aware versus tag-unaware switching
// R3 - control bit 8 adds tag encapsulation on host port 2 receive
// R4 - bit 7: port 2 tx flow control when own rx usage reaches threshold
// R5 - bits 6,5: port 2 tx flow control from port 1/0 tx usage
// R6 - bits 4,3 with port 1 MAC enable: port 1 rx flow control
// R7 - bits 2,1 with port 0 MAC enable: port 0 rx flow control
// R8 - control bit 0 loops each received packet back to same port
// R9 - loopback forces port 2 receive onto DMA channel zero
// R10 - loopback bumps frame-start overrun statistic per looped packet
// R11 - writing one resets switch; bit reads one until reset done
// R12 - per port statistics kept only while its enable bit is one
// R13 - port 2 statistics count only frame-start overruns
// R14 - priority type bits 10,9,8 select fixed or escalating priority
// R15 - escalation quota in bits 4-0 passes higher packets before lower
// R16 - host tx block limit in bits 8-4, never below 0eh
// R17 - host rx block limit in bits 3-0, kept between 3h and 6h
// R18 - read-only host tx and rx blocks in use counts
// R19 - port 0 thresholds: bits 12-8 from port 2, bits 4-0 from port 1
// R20 - flow-control request drops once usage below threshold or disabled
//
// Design decisions made here: the address map and the AHB-Lite slave port.
`include "spc_map.vh"
`timescale 1ns/1ns
`default_nettype none
module spc_switch_port_control
(
    input  wire        clk_sys,
    input  wire        rst,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    input  wire [4:0]  p0_tx_blocks_in_use,
    input  wire [3:0]  p0_rx_blocks_in_use,
    input  wire [4:0]  p1_tx_blocks_in_use,
    input  wire [4:0]  p2_tx_blocks_in_use,
    input  wire [4:0]  p2_rx_blocks_in_use,
    input  wire        port0_mac_rx_fc_en,
    input  wire        port1_mac_rx_fc_en,
    input  wire        loop_pkt_done,
    input  wire [2:0]  rx_ch_select,
    output reg  [2:0]  keep_prio_tag,
    output reg  [11:0] port_default_vlan_id,
    output reg         tag_aware_mode,
    output reg         host_rx_tag_encapsulate,
    output reg         fifo_loopback,
    output reg  [2:0]  port2_rx_channel,
    output reg         loop_overrun_inc,
    output reg         port2_tx_fc,
    output reg         port1_rx_fc,
    output reg         port0_rx_fc,
    output reg         switch_reset,
    output reg  [2:0]  counting_on,
    output reg         port2_overrun_only,
    output reg  [2:0]  prio_escalation,
    output reg  [4:0]  escalation_packet_quota,
    output reg  [4:0]  host_tx_block_limit,
    output reg  [3:0]  host_rx_block_limit
);

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    reg [`SPC_CTL_W-1:0] ctl_r;
    reg [`SPC_PT_W-1:0]  ptype_r;
    reg [2:0]            stat_en_r;
    reg [8:0]            max_blks_r;
    reg [4:0]            p0_thr_p2_r;
    reg [4:0]            p0_thr_p1_r;
    reg [4:0]            p1_thr_p2_r;
    reg [4:0]            p1_thr_p0_r;
    reg [4:0]            p2_thr_own_r;
    reg [4:0]            p2_thr_p1_r;
    reg [4:0]            p2_thr_p0_r;
    reg [11:0]           vid_r;
    reg                  srst_pend_r;
    reg [3:0]            srst_cnt_r;
    reg                  wr_pend_r;
    reg [11:0]           wr_addr_r;
    reg [31:0]           rd_nxt;
    reg [4:0]            tx_lim_nxt;
    reg [3:0]            rx_lim_nxt;

    wire addr_ph = hsel & hready & htrans[1];
    // read word picked in address phase so it stands through the data phase
    wire [11:0] rd_addr_r = {haddr[11:2], 2'b00};

    //------------------------------------------------------------
    // limit clamping of host block limits
    //------------------------------------------------------------
    always @*
    begin
        tx_lim_nxt = hwdata[8:4];
        rx_lim_nxt = hwdata[3:0];
        if (tx_lim_nxt < `SPC_TX_MIN)
            tx_lim_nxt = `SPC_TX_MIN; // R16
        if (rx_lim_nxt < `SPC_RX_MIN)
            rx_lim_nxt = `SPC_RX_MIN; // R17
        else if (rx_lim_nxt > `SPC_RX_MAX)
            rx_lim_nxt = `SPC_RX_MAX; // R17
    end

    //------------------------------------------------------------
    // read mux
    //------------------------------------------------------------
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        if (rd_addr_r == `SPC_OFS_CONTROL)
            rd_nxt[`SPC_CTL_W-1:0] = ctl_r;
        else if (rd_addr_r == `SPC_OFS_SOFT_RESET)
            rd_nxt[0] = srst_pend_r; // R11
        else if (rd_addr_r == `SPC_OFS_STAT_EN)
            rd_nxt[2:0] = stat_en_r;
        else if (rd_addr_r == `SPC_OFS_PTYPE)
            rd_nxt[`SPC_PT_W-1:0] = ptype_r;
        else if (rd_addr_r == `SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS)
            rd_nxt[8:0] = max_blks_r;
        else if (rd_addr_r == `SPC_OFS_P0_BLK_USE)
            rd_nxt[8:0] = {p0_tx_blocks_in_use, p0_rx_blocks_in_use}; // R18
        else if (rd_addr_r == `SPC_OFS_P0_THRESH)
            rd_nxt[12:0] = {p0_thr_p2_r, 3'h0, p0_thr_p1_r}; // R19
        else if (rd_addr_r == `SPC_OFS_P1_THRESH)
            rd_nxt[12:0] = {p1_thr_p2_r, 3'h0, p1_thr_p0_r};
        else if (rd_addr_r == `SPC_OFS_P2_THRESH)
            rd_nxt[20:0] = {p2_thr_own_r, 3'h0, p2_thr_p1_r, 3'h0, p2_thr_p0_r};
        else if (rd_addr_r == `SPC_OFS_VLAN_ID)
            rd_nxt[11:0] = vid_r;
    end

    //------------------------------------------------------------
    // AHB-Lite slave: zero wait, data written in data phase
    //------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            if (hready)
            begin
                wr_pend_r <= addr_ph & hwrite;
                wr_addr_r <= {haddr[11:2], 2'b00};
            end
            hrdata <= (hready & addr_ph & ~hwrite) ? rd_nxt : 32'h0000_0000;
        end
    end

    //------------------------------------------------------------
    // configuration registers and soft reset
    //------------------------------------------------------------
    wire wr_now  = wr_pend_r;
    wire srst_go = wr_now && (wr_addr_r == `SPC_OFS_SOFT_RESET) && hwdata[0];

    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctl_r        <= `SPC_CTL_RESET;
            ptype_r      <= `SPC_PT_RESET;
            stat_en_r    <= `SPC_STAT_RESET;
            max_blks_r   <= `SPC_MAX_RESET;
            p0_thr_p2_r  <= `SPC_THR_RESET;
            p0_thr_p1_r  <= `SPC_THR_RESET;
            p1_thr_p2_r  <= `SPC_THR_RESET;
            p1_thr_p0_r  <= `SPC_THR_RESET;
            p2_thr_own_r <= `SPC_THR_RESET;
            p2_thr_p1_r  <= `SPC_THR_RESET;
            p2_thr_p0_r  <= `SPC_THR_RESET;
            vid_r        <= `SPC_VID_RESET;
            srst_pend_r  <= 1'b0;
            srst_cnt_r   <= 4'h0;
        end
        else if (srst_pend_r)
        begin
            // switch logic held in reset while registers are reloaded with reset values every cycle
            ctl_r        <= `SPC_CTL_RESET; // R11
            ptype_r      <= `SPC_PT_RESET;
            stat_en_r    <= `SPC_STAT_RESET;
            max_blks_r   <= `SPC_MAX_RESET;
            p0_thr_p2_r  <= `SPC_THR_RESET;
            p0_thr_p1_r  <= `SPC_THR_RESET;
            p1_thr_p2_r  <= `SPC_THR_RESET;
            p1_thr_p0_r  <= `SPC_THR_RESET;
            p2_thr_own_r <= `SPC_THR_RESET;
            p2_thr_p1_r  <= `SPC_THR_RESET;
            p2_thr_p0_r  <= `SPC_THR_RESET;
            vid_r        <= `SPC_VID_RESET;
            srst_cnt_r   <= srst_cnt_r - 4'h1;
            if (srst_cnt_r == 4'h1)
                srst_pend_r <= 1'b0; // R11
        end
        else if (wr_now)
        begin
            if (wr_addr_r == `SPC_OFS_CONTROL)
                ctl_r <= hwdata[`SPC_CTL_W-1:0];
            else if (srst_go)
            begin
                srst_pend_r <= 1'b1; // R11
                srst_cnt_r  <= `SPC_SRST_CYCLES;
            end
            else if (wr_addr_r == `SPC_OFS_STAT_EN)
                stat_en_r <= hwdata[2:0];
            else if (wr_addr_r == `SPC_OFS_PTYPE)
                ptype_r <= {hwdata[10:8], 3'h0, hwdata[4:0]};
            else if (wr_addr_r == `SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS)
                max_blks_r <= {tx_lim_nxt, rx_lim_nxt}; // R16 R17
            else if (wr_addr_r == `SPC_OFS_P0_THRESH)
            begin
                p0_thr_p2_r <= hwdata[12:8]; // R19
                p0_thr_p1_r <= hwdata[4:0]; // R19
            end
            else if (wr_addr_r == `SPC_OFS_P1_THRESH)
            begin
                p1_thr_p2_r <= hwdata[12:8];
                p1_thr_p0_r <= hwdata[4:0];
            end
            else if (wr_addr_r == `SPC_OFS_P2_THRESH)
            begin
                p2_thr_own_r <= hwdata[20:16];
                p2_thr_p1_r  <= hwdata[12:8];
                p2_thr_p0_r  <= hwdata[4:0];
            end
            else if (wr_addr_r == `SPC_OFS_VLAN_ID)
                vid_r <= hwdata[11:0];
        end
    end

    //------------------------------------------------------------
    // flow-control triggers, level while usage at or above level
    //------------------------------------------------------------
    wire fc2_nxt = (ctl_r[`SPC_CTL_P2_OWN_RX] && p2_rx_blocks_in_use >= p2_thr_own_r) // R4 R20
                || (ctl_r[`SPC_CTL_P2_FROM_P1] && p1_tx_blocks_in_use >= p2_thr_p1_r) // R5
                || (ctl_r[`SPC_CTL_P2_FROM_P0] && p0_tx_blocks_in_use >= p2_thr_p0_r); // R5
    wire fc1_nxt = port1_mac_rx_fc_en && // R6 R20
                   ((ctl_r[`SPC_CTL_P1_FROM_P2] && p2_tx_blocks_in_use >= p1_thr_p2_r)
                 || (ctl_r[`SPC_CTL_P1_FROM_P0] && p0_tx_blocks_in_use >= p1_thr_p0_r));
    wire fc0_nxt = port0_mac_rx_fc_en && // R7 R20
                   ((ctl_r[`SPC_CTL_P0_FROM_P2] && p2_tx_blocks_in_use >= p0_thr_p2_r)
                 || (ctl_r[`SPC_CTL_P0_FROM_P1] && p1_tx_blocks_in_use >= p0_thr_p1_r));

    //------------------------------------------------------------
    // registered outputs to switch core
    //------------------------------------------------------------
    always @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            keep_prio_tag           <= 3'h0;
            port_default_vlan_id    <= 12'h000;
            tag_aware_mode          <= 1'b0;
            host_rx_tag_encapsulate <= 1'b0;
            fifo_loopback           <= 1'b0;
            port2_rx_channel        <= 3'h0;
            loop_overrun_inc        <= 1'b0;
            port2_tx_fc             <= 1'b0;
            port1_rx_fc             <= 1'b0;
            port0_rx_fc             <= 1'b0;
            switch_reset            <= 1'b0;
            counting_on             <= 3'h0;
            port2_overrun_only      <= 1'b0;
            prio_escalation         <= 3'h0;
            escalation_packet_quota <= 5'h00;
            host_tx_block_limit     <= 5'h00;
            host_rx_block_limit     <= 4'h0;
        end
        else
        begin
            keep_prio_tag <= {ctl_r[`SPC_CTL_P2_KEEP], ctl_r[`SPC_CTL_P1_KEEP],
                              ctl_r[`SPC_CTL_P0_KEEP]}; // R1
            port_default_vlan_id    <= vid_r; // R1
            tag_aware_mode          <= ctl_r[`SPC_CTL_TAG_AWARE]; // R2
            host_rx_tag_encapsulate <= ctl_r[`SPC_CTL_ENCAP]; // R3
            fifo_loopback           <= ctl_r[`SPC_CTL_LOOPBACK]; // R8
            port2_rx_channel <= ctl_r[`SPC_CTL_LOOPBACK] ? 3'h0 : rx_ch_select; // R9
            loop_overrun_inc <= ctl_r[`SPC_CTL_LOOPBACK] & loop_pkt_done; // R10
            port2_tx_fc             <= fc2_nxt;
            port1_rx_fc             <= fc1_nxt;
            port0_rx_fc             <= fc0_nxt;
            switch_reset            <= srst_pend_r; // R11
            counting_on             <= stat_en_r; // R12
            port2_overrun_only      <= stat_en_r[2]; // R13
            prio_escalation <= {ptype_r[`SPC_PT_P2_ESC], ptype_r[`SPC_PT_P1_ESC],
                                ptype_r[`SPC_PT_P0_ESC]}; // R14
            escalation_packet_quota <= ptype_r[4:0]; // R15
            host_tx_block_limit     <= max_blks_r[8:4]; // R16
            host_rx_block_limit     <= max_blks_r[3:0]; // R17
        end
    end

endmodule
`default_nettype wire

// ---- verif/spc_switch_port_control_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module spc_switch_port_control_props
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        port0_mac_rx_fc_en,
    input wire logic        port1_mac_rx_fc_en,
    input wire logic        loop_pkt_done,
    input wire logic [2:0]  rx_ch_select,
    input wire logic        fifo_loopback,
    input wire logic [2:0]  port2_rx_channel,
    input wire logic        loop_overrun_inc,
    input wire logic        port2_tx_fc,
    input wire logic        port0_rx_fc,
    input wire logic        port1_rx_fc,
    input wire logic        switch_reset,
    input wire logic [2:0]  counting_on,
    input wire logic        port2_overrun_only,
    input wire logic [4:0]  host_tx_block_limit,
    input wire logic [3:0]  host_rx_block_limit
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_rdata_idle: assert property (!$past(hsel && hready && htrans[1] && !hwrite) |-> hrdata == 0)
        else $error("read data outside data phase");
    a_loop_chan_zero: assert property (fifo_loopback && $past(fifo_loopback) |-> port2_rx_channel == 0)
        else $error("loopback channel not zero");
    a_chan_follow: assert property (!$past(rst) && !fifo_loopback && !$past(fifo_loopback)
        |-> port2_rx_channel == $past(rx_ch_select))
        else $error("channel does not follow select");
    a_overrun_pulse: assert property (loop_pkt_done && fifo_loopback |=> loop_overrun_inc)
        else $error("overrun pulse missing");
    a_overrun_cause: assert property (loop_overrun_inc |-> $past(loop_pkt_done))
        else $error("overrun pulse without packet");
    a_p0_mac_gate: assert property (!$past(port0_mac_rx_fc_en) |-> !port0_rx_fc)
        else $error("port0 flow control without mac enable");
    a_p1_mac_gate: assert property (!$past(port1_mac_rx_fc_en) |-> !port1_rx_fc)
        else $error("port1 flow control without mac enable");
    a_p2_stat_only: assert property (port2_overrun_only == counting_on[2])
        else $error("port2 overrun only mismatch");
    a_limit_range: assert property (!$past(rst) |-> host_tx_block_limit >= 5'h0e
        && host_rx_block_limit >= 4'h3 && host_rx_block_limit <= 4'h6)
        else $error("block limit out of range");
    a_srst_len: assert property ($rose(switch_reset) |-> switch_reset[*4] ##1 !switch_reset)
        else $error("soft reset length wrong");
    a_srst_clears: assert property ($fell(switch_reset) |-> !fifo_loopback
        && host_rx_block_limit == 4'h3)
        else $error("soft reset left config");
    c_overrun: cover property (loop_overrun_inc);
    c_p2_fc: cover property (port2_tx_fc);
    c_srst_done: cover property ($fell(switch_reset));
endmodule
bind spc_switch_port_control spc_switch_port_control_props u_props (.*);
`default_nettype wire

// ---- verif/tb_switch_port_control.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "spc_map.vh"
module tb_switch_port_control;
    logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, loop_pkt_done;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, rx_ch_select, keep_prio_tag, port2_rx_channel, counting_on, prio_escalation;
    logic [11:0] port_default_vlan_id;
    logic [4:0]  p0_tx_blocks_in_use, p1_tx_blocks_in_use, p2_tx_blocks_in_use;
    logic [4:0]  p2_rx_blocks_in_use, escalation_packet_quota, host_tx_block_limit;
    logic [3:0]  p0_rx_blocks_in_use, host_rx_block_limit;
    logic        port0_mac_rx_fc_en, port1_mac_rx_fc_en, tag_aware_mode, host_rx_tag_encapsulate;
    logic        fifo_loopback, loop_overrun_inc, port2_tx_fc, port1_rx_fc, port0_rx_fc;
    logic        switch_reset, port2_overrun_only;
    int          fails, n_checks, cyc;
    wire [2:0]   fcv = {port2_tx_fc, port1_rx_fc, port0_rx_fc};
    assign hready = hreadyout;
    spc_switch_port_control u_spc_switch_port_control (.*);
    initial
    begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            fails++;
            close_out();
        end
    end
    // ----------------------------------------
    // bus and check helpers
    // ----------------------------------------
    task close_out;
        if (fails == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1; htrans <= 2'b10; haddr <= {20'h0, a}; hwrite <= wr; hsize <= 3'b010;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'b00; hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task wr_rd(input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp, input string nm);
        ahb(1, a, wd);
        ahb(0, a, 0);
        chk(nm, exp, rd);
    endtask
    task pulse;
        @(posedge clk_sys) loop_pkt_done <= 1;
        @(posedge clk_sys) loop_pkt_done <= 0;
        #1;
    endtask
    task use_set(input int s, input logic [4:0] v, input logic m);
        @(posedge clk_sys);
        p0_tx_blocks_in_use <= (s == 0) ? v : 5'h0;
        p1_tx_blocks_in_use <= (s == 1) ? v : 5'h0;
        p2_tx_blocks_in_use <= (s == 2) ? v : 5'h0;
        p2_rx_blocks_in_use <= (s == 3) ? v : 5'h0;
        {port0_mac_rx_fc_en, port1_mac_rx_fc_en} <= {m, m};
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        ahb(0, `SPC_OFS_CONTROL, 0); chk("control_rst", 32'h000000e0, rd);
        ahb(0, `SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS, 0); chk("max_rst", 32'h00000113, rd);
        wr_rd(12'h100, 32'hffffffff, 32'h0, "unmapped");
    endtask
    task t_control;
        logic [31:0] v [3];
        v = '{32'hffffffff, 32'h00000a55, 32'h00001500};
        foreach (v[i])
        begin
            wr_rd(`SPC_OFS_CONTROL, v[i], {19'h0, v[i][12:0]}, "control");
            chk("keep_tag", v[i][12:10], keep_prio_tag);
            chk("aware", v[i][9], tag_aware_mode);
            chk("encap", v[i][8], host_rx_tag_encapsulate);
            chk("loop", v[i][0], fifo_loopback);
        end
        wr_rd(`SPC_OFS_VLAN_ID, 32'hffffffff, 32'h00000fff, "vlan_id");
        chk("vlan_out", 32'hfff, port_default_vlan_id);
    endtask
    task t_loop;
        wr_rd(`SPC_OFS_CONTROL, 32'h1, 32'h1, "control");
        chk("chan_loop", 0, port2_rx_channel);
        pulse; chk("overrun_on", 1, loop_overrun_inc);
        wr_rd(`SPC_OFS_CONTROL, 32'h0, 32'h0, "control");
        chk("chan_norm", 5, port2_rx_channel);
        pulse; chk("overrun_off", 0, loop_overrun_inc);
    endtask
    task t_fc;
        int bt[7] = '{7, 6, 5, 4, 3, 2, 1};
        int sr[7] = '{3, 1, 0, 2, 0, 2, 1};
        int th[7] = '{9, 7, 5, 12, 6, 8, 10};
        int ds[7] = '{2, 2, 2, 1, 1, 0, 0};
        ahb(1, `SPC_OFS_P0_THRESH, 32'h0000080a);
        ahb(1, `SPC_OFS_P1_THRESH, 32'h00000c06);
        ahb(1, `SPC_OFS_P2_THRESH, 32'h00090705);
        ahb(0, `SPC_OFS_P0_THRESH, 0); chk("p0_thresh", 32'h0000080a, rd);
        for (int i = 0; i < 7; i++)
        begin
            ahb(1, `SPC_OFS_CONTROL, 32'h1 << bt[i]);
            use_set(sr[i], th[i], 1); chk("fc_at", 1 << ds[i], fcv);
            use_set(sr[i], th[i] - 1, 1); chk("fc_below", 0, fcv);
            use_set(sr[i], th[i], 0); chk("fc_mac", (ds[i] == 2) ? 4 : 0, fcv);
            ahb(1, `SPC_OFS_CONTROL, 0);
            @(posedge clk_sys); #1;
            chk("fc_off", 0, fcv);
        end
        use_set(0, 0, 1);
    endtask
    task t_stat;
        wr_rd(`SPC_OFS_STAT_EN, 32'hffffffff, 32'h7, "stat_en");
        chk("counting", 7, counting_on); chk("p2_only", 1, port2_overrun_only);
        wr_rd(`SPC_OFS_STAT_EN, 32'h2, 32'h2, "stat_en");
        chk("counting", 2, counting_on); chk("p2_only", 0, port2_overrun_only);
        wr_rd(`SPC_OFS_PTYPE, 32'hffffffff, 32'h0000071f, "ptype");
        chk("esc", 7, prio_escalation); chk("quota", 32'h1f, escalation_packet_quota);
        wr_rd(`SPC_OFS_PTYPE, 32'h00000512, 32'h00000512, "ptype");
        chk("esc", 5, prio_escalation); chk("quota", 32'h12, escalation_packet_quota);
    endtask
    task t_blocks;
        wr_rd(`SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS, 32'h000000a2, 32'h000000e3, "max_lo");
        chk("tx_lim", 32'h0e, host_tx_block_limit); chk("rx_lim", 3, host_rx_block_limit);
        wr_rd(`SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS, 32'h00000157, 32'h00000156, "max_hi");
        wr_rd(`SPC_OFS_HOST_PORT_FIFO_BLOCK_LIMITS, 32'h000000e4, 32'h000000e4, "max_edge");
        @(posedge clk_sys)
        begin
            p0_tx_blocks_in_use <= 5'h13;
            p0_rx_blocks_in_use <= 4'ha;
        end
        wr_rd(`SPC_OFS_P0_BLK_USE, 32'hffffffff, 32'h0000013a, "blk_use");
    endtask
    task t_soft;
        ahb(1, `SPC_OFS_CONTROL, 32'h1);
        ahb(1, `SPC_OFS_SOFT_RESET, 32'h1);
        ahb(0, `SPC_OFS_SOFT_RESET, 0); chk("srst_pend", 1, rd);
        for (int k = 0; k < 8 && rd[0] !== 1'b0; k++)
            ahb(0, `SPC_OFS_SOFT_RESET, 0);
        chk("srst_done", 0, rd);
        ahb(0, `SPC_OFS_CONTROL, 0); chk("ctl_after", 32'h000000e0, rd);
    endtask
    initial
    begin
        rst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'b010; hwdata = 0;
        p0_tx_blocks_in_use = 0; p0_rx_blocks_in_use = 0; p1_tx_blocks_in_use = 0;
        p2_tx_blocks_in_use = 0; p2_rx_blocks_in_use = 0; loop_pkt_done = 0;
        port0_mac_rx_fc_en = 1; port1_mac_rx_fc_en = 1; rx_ch_select = 3'h5;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        t_reset; t_control; t_loop; t_fc; t_stat; t_blocks; t_soft;
        close_out();
    end
endmodule
`default_nettype wire
